/* rtl/dcr_event_irq.sv */
`default_nettype none

// -----------------------------------------------------------------------------
// Sticky event status, enable gating and one level interrupt
// -----------------------------------------------------------------------------
module dcr_event_irq #(
  parameter int unsigned N = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Events and software control
  input wire logic [N-1:0] event_pulse,
  input wire logic [N-1:0] clear,
  input wire logic [N-1:0] enable,
  // Results
  output logic [N-1:0] status,
  output logic irq
);

  logic [N-1:0] status_q;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear) | event_pulse;
    end
  end

  assign status = status_q;
  assign irq = |(status_q & enable);

endmodule : dcr_event_irq

`default_nettype wire

/* rtl/dcr_latency_meter.sv */
`default_nettype none

// -----------------------------------------------------------------------------
// Cycle counter between a start pulse and a stop pulse
// -----------------------------------------------------------------------------
module dcr_latency_meter #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Event pulses
  input wire logic start,
  input wire logic stop,
  // Result
  output logic [W-1:0] latency,
  output logic done
);

  logic busy_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] latency_q;
  logic done_q;

  // Counting saturates so that a lost stop never wraps to a small, plausible value.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (start && !stop) begin
      busy_q <= 1'b1;
      cnt_q <= {{(W-1){1'b0}}, 1'b1};
    end else if (stop) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (busy_q && (cnt_q != {W{1'b1}})) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Result is latched on stop; a stop in the start cycle measures zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      latency_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= stop && (busy_q || start);
      if (stop && start) begin
        latency_q <= '0;
      end else if (stop && busy_q) begin
        latency_q <= cnt_q;
      end
    end
  end

  assign latency = latency_q;
  assign done = done_q;

endmodule : dcr_latency_meter

`default_nettype wire

/* rtl/dcr_pkg.sv */
`default_nettype none

package dcr_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------------------
  // Byte addresses; each 64-bit register is a low word and a high word
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ECC_DATA_LO_ADDR = 12'h1A0;
  localparam logic [11:0] ECC_DATA_HI_ADDR = 12'h1A4;
  localparam logic [11:0] CKE_LO_ADDR = 12'h1B0;
  localparam logic [11:0] CKE_HI_ADDR = 12'h1B4;
  localparam logic [11:0] WRLAT_LO_ADDR = 12'h1D0;
  localparam logic [11:0] WRLAT_HI_ADDR = 12'h1D4;
  localparam logic [11:0] UPD_LO_ADDR = 12'h1E0;
  localparam logic [11:0] UPD_HI_ADDR = 12'h1E4;
  localparam logic [11:0] DLL0_LO_ADDR = 12'h1F0;
  localparam logic [11:0] DLL0_HI_ADDR = 12'h1F4;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h300;
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h304;
  localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h308;

  // ---------------------------------------------------------------------------
  // Field positions within a 32-bit word
  // ---------------------------------------------------------------------------
  localparam int unsigned CKE_LSB = 0;            // Low word bits 2:0.
  localparam int unsigned WRLAT_BASE_LSB = 24;    // High word, bits 59:56.
  localparam int unsigned WRLAT_OBS_LSB = 16;     // High word, bits 51:48.
  localparam int unsigned UPD_MIN_LSB = 0;        // High word, bits 35:32.
  localparam int unsigned CLK_DIS_LSB = 16;       // Low word, bits 19:16.
  localparam int unsigned TERM_ALT_BIT = 8;       // Low word, bit 8.
  localparam int unsigned IDLE_DRIVE_BIT = 0;     // Low word, bit 0.
  localparam int unsigned PHYUPD_TYPE_LSB = 16;   // High word, bits 61:48.
  localparam int unsigned PHYUPD_RESP_LSB = 0;    // High word, bits 45:32.
  localparam int unsigned CTRLUPD_MAX_LSB = 16;   // Low word, bits 29:16.
  localparam int unsigned RDEN_BASE_LSB = 8;      // Low word, bits 12:8.
  localparam int unsigned RDLAT_OBS_LSB = 0;      // Low word, bits 4:0.
  localparam int unsigned DLL_OFF_BIT = 24;
  localparam int unsigned DLL_PHASE_LSB = 16;
  localparam int unsigned DLL_PREC_LSB = 0;

  // ---------------------------------------------------------------------------
  // Field widths
  // ---------------------------------------------------------------------------
  localparam int unsigned CKE_W = 3;
  localparam int unsigned WRLAT_W = 4;
  localparam int unsigned RDLAT_W = 5;
  localparam int unsigned CS_N = 4;
  localparam int unsigned REFRESH_INTERVAL_W = 14;
  localparam int unsigned UPD_MIN_W = 4;
  localparam int unsigned DLL_BYTE_W = 8;
  localparam int unsigned EVT_N = 3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CKE_RST = 3'h0;
  localparam logic [3:0] WRLAT_BASE_RST = 4'h0;
  localparam logic [3:0] UPD_MIN_RST = 4'h4;
  localparam logic [3:0] CLK_DIS_RST = 4'h0;
  localparam logic [4:0] RDEN_BASE_RST = 5'h00;
  localparam logic [31:0] DLL0_RST = 32'h00000000;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // ---------------------------------------------------------------------------
  // Event bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned EVT_ECC_UNCORR = 0;
  localparam int unsigned EVT_WRLAT = 1;
  localparam int unsigned EVT_RDLAT = 2;

endpackage : dcr_pkg

`default_nettype wire

/* rtl/dcr_regs.sv */
// Added by the designer: the APB interface to the registers.
`default_nettype none


module dcr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ECC error capture
  input wire logic ecc_uncorr_valid,
  input wire logic [63:0] ecc_uncorr_data,
  // Latency measurement events from the command path
  input wire logic wr_cmd_issue,
  input wire logic wr_data_issue,
  input wire logic rd_cmd_issue,
  input wire logic rd_data_return,
  // Refresh interval from the timing registers
  input wire logic [13:0] refresh_interval,
  // Controller state
  input wire logic ctrl_idle,
  // Configuration outputs
  output logic [2:0] cke_delay,
  output logic [3:0] write_latency_base,
  output logic [4:0] read_enable_base,
  output logic termination_alt_enable,
  output logic [3:0] ctrl_update_min_time,
  output logic [13:0] ctrl_update_max_time,
  output logic [13:0] phy_update_type_time,
  output logic [13:0] phy_update_response_time,
  // DRAM clock gating and data bus drive
  output logic [3:0] dram_clk_en,
  output logic dq_dqs_idle_oe,
  // Lane 0 DLL
  output logic dll0_enable,
  output logic [7:0] dll0_phase,
  output logic [7:0] dll0_precision,
  // Interrupt
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Address decode helper
  // ---------------------------------------------------------------------------

  // Word addresses only; byte offset bits are ignored.
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
    addr_is = (a[11:2] == target[11:2]);
  endfunction : addr_is

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------

  logic [63:0] ecc_data_q;
  logic [2:0] cke_delay_q;
  logic [3:0] wrlat_base_q;
  logic [3:0] clk_dis_q;
  logic term_alt_q;
  logic idle_drive_q;
  logic [4:0] rden_base_q;
  logic [31:0] dll0_q;
  logic [2:0] irq_en_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] wrlat_obs;
  logic [4:0] rdlat_obs;
  logic wrlat_done;
  logic rdlat_done;
  logic [2:0] irq_status;
  logic [2:0] irq_clear;
  logic [2:0] events;
  logic wr_en;
  logic setup;
  logic mapped;

  // ---------------------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------------------

  // Read data is prepared in the setup cycle, so the slave answers in the first
  // access cycle with zero wait states.
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    mapped = addr_is(paddr, dcr_pkg::ECC_DATA_LO_ADDR) ||
             addr_is(paddr, dcr_pkg::ECC_DATA_HI_ADDR) ||
             addr_is(paddr, dcr_pkg::CKE_LO_ADDR) ||
             addr_is(paddr, dcr_pkg::CKE_HI_ADDR) ||
             addr_is(paddr, dcr_pkg::WRLAT_LO_ADDR) ||
             addr_is(paddr, dcr_pkg::WRLAT_HI_ADDR) ||
             addr_is(paddr, dcr_pkg::UPD_LO_ADDR) ||
             addr_is(paddr, dcr_pkg::UPD_HI_ADDR) ||
             addr_is(paddr, dcr_pkg::DLL0_LO_ADDR) ||
             addr_is(paddr, dcr_pkg::DLL0_HI_ADDR) ||
             addr_is(paddr, dcr_pkg::IRQ_STATUS_ADDR) ||
             addr_is(paddr, dcr_pkg::IRQ_ENABLE_ADDR) ||
             addr_is(paddr, dcr_pkg::IRQ_CLEAR_ADDR);
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------

  // Unmapped addresses and write-only words read as zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped;
      prdata_q <= 32'h00000000;
      if (addr_is(paddr, dcr_pkg::ECC_DATA_LO_ADDR)) begin
        prdata_q <= ecc_data_q[31:0];
      end else if (addr_is(paddr, dcr_pkg::ECC_DATA_HI_ADDR)) begin
        prdata_q <= ecc_data_q[63:32];
      end else if (addr_is(paddr, dcr_pkg::CKE_LO_ADDR)) begin
        prdata_q[dcr_pkg::CKE_LSB +: dcr_pkg::CKE_W] <= cke_delay_q;
      end else if (addr_is(paddr, dcr_pkg::WRLAT_LO_ADDR)) begin
        prdata_q[dcr_pkg::CLK_DIS_LSB +: dcr_pkg::CS_N] <= clk_dis_q;
        prdata_q[dcr_pkg::TERM_ALT_BIT] <= term_alt_q;
        prdata_q[dcr_pkg::IDLE_DRIVE_BIT] <= idle_drive_q;
      end else if (addr_is(paddr, dcr_pkg::WRLAT_HI_ADDR)) begin
        prdata_q[dcr_pkg::WRLAT_BASE_LSB +: dcr_pkg::WRLAT_W] <= wrlat_base_q;
        prdata_q[dcr_pkg::WRLAT_OBS_LSB +: dcr_pkg::WRLAT_W] <= wrlat_obs;
        prdata_q[dcr_pkg::UPD_MIN_LSB +: dcr_pkg::UPD_MIN_W] <= dcr_pkg::UPD_MIN_RST;
      end else if (addr_is(paddr, dcr_pkg::UPD_LO_ADDR)) begin
        prdata_q[dcr_pkg::CTRLUPD_MAX_LSB +: dcr_pkg::REFRESH_INTERVAL_W] <= refresh_interval;
        prdata_q[dcr_pkg::RDEN_BASE_LSB +: dcr_pkg::RDLAT_W] <= rden_base_q;
        prdata_q[dcr_pkg::RDLAT_OBS_LSB +: dcr_pkg::RDLAT_W] <= rdlat_obs;
      end else if (addr_is(paddr, dcr_pkg::UPD_HI_ADDR)) begin
        prdata_q[dcr_pkg::PHYUPD_TYPE_LSB +: dcr_pkg::REFRESH_INTERVAL_W] <= refresh_interval;
        prdata_q[dcr_pkg::PHYUPD_RESP_LSB +: dcr_pkg::REFRESH_INTERVAL_W] <= refresh_interval;
      end else if (addr_is(paddr, dcr_pkg::DLL0_HI_ADDR)) begin
        prdata_q <= dll0_q;
      end else if (addr_is(paddr, dcr_pkg::IRQ_STATUS_ADDR)) begin
        prdata_q[dcr_pkg::EVT_N-1:0] <= irq_status;
      end else if (addr_is(paddr, dcr_pkg::IRQ_ENABLE_ADDR)) begin
        prdata_q[dcr_pkg::EVT_N-1:0] <= irq_en_q;
      end
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q && pready;

  // ---------------------------------------------------------------------------
  // ECC uncorrectable data capture
  // ---------------------------------------------------------------------------

  // Only the error path loads this register; bus writes never reach it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ecc_data_q <= 64'h0000000000000000;
    end else if (ecc_uncorr_valid) begin
      ecc_data_q <= ecc_uncorr_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Self-refresh CKE delay
  // ---------------------------------------------------------------------------

  // Kept for software compatibility; the self-refresh path here ignores it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cke_delay_q <= dcr_pkg::CKE_RST;
    end else if (wr_en && addr_is(paddr, dcr_pkg::CKE_LO_ADDR)) begin
      cke_delay_q <= pwdata[dcr_pkg::CKE_LSB +: dcr_pkg::CKE_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Write latency base and pad control
  // ---------------------------------------------------------------------------

  // Writes to the high word touch only the base; observed latency and the
  // update minimum are not stored here, so a write cannot alter them.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wrlat_base_q <= dcr_pkg::WRLAT_BASE_RST;
    end else if (wr_en && addr_is(paddr, dcr_pkg::WRLAT_HI_ADDR)) begin
      wrlat_base_q <= pwdata[dcr_pkg::WRLAT_BASE_LSB +: dcr_pkg::WRLAT_W];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_dis_q <= dcr_pkg::CLK_DIS_RST;
      term_alt_q <= 1'b0;
      idle_drive_q <= 1'b0;
    end else if (wr_en && addr_is(paddr, dcr_pkg::WRLAT_LO_ADDR)) begin
      clk_dis_q <= pwdata[dcr_pkg::CLK_DIS_LSB +: dcr_pkg::CS_N];
      term_alt_q <= pwdata[dcr_pkg::TERM_ALT_BIT];
      idle_drive_q <= pwdata[dcr_pkg::IDLE_DRIVE_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Read enable base
  // ---------------------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rden_base_q <= dcr_pkg::RDEN_BASE_RST;
    end else if (wr_en && addr_is(paddr, dcr_pkg::UPD_LO_ADDR)) begin
      rden_base_q <= pwdata[dcr_pkg::RDEN_BASE_LSB +: dcr_pkg::RDLAT_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Lane 0 DLL control word
  // ---------------------------------------------------------------------------

  // The low word of this register is reserved and reads as zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dll0_q <= dcr_pkg::DLL0_RST;
    end else if (wr_en && addr_is(paddr, dcr_pkg::DLL0_HI_ADDR)) begin
      dll0_q <= pwdata;
    end
  end

  // Bit 24 is an active-low enable, so the reset word leaves the DLL running.
  assign dll0_enable = !dll0_q[dcr_pkg::DLL_OFF_BIT];
  assign dll0_phase = dll0_q[dcr_pkg::DLL_PHASE_LSB +: dcr_pkg::DLL_BYTE_W];
  assign dll0_precision = dll0_q[dcr_pkg::DLL_PREC_LSB +: dcr_pkg::DLL_BYTE_W];

  // ---------------------------------------------------------------------------
  // Observed latencies
  // ---------------------------------------------------------------------------

  dcr_latency_meter #(
    .W(dcr_pkg::WRLAT_W)
  ) u_wr_meter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(wr_cmd_issue),
    .stop(wr_data_issue),
    .latency(wrlat_obs),
    .done(wrlat_done)
  );

  dcr_latency_meter #(
    .W(dcr_pkg::RDLAT_W)
  ) u_rd_meter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(rd_cmd_issue),
    .stop(rd_data_return),
    .latency(rdlat_obs),
    .done(rdlat_done)
  );

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= dcr_pkg::IRQ_EN_RST;
    end else if (wr_en && addr_is(paddr, dcr_pkg::IRQ_ENABLE_ADDR)) begin
      irq_en_q <= pwdata[dcr_pkg::EVT_N-1:0];
    end
  end

  // Clear is write-one-to-clear and self-resetting; it stores nothing.
  assign irq_clear = (wr_en && addr_is(paddr, dcr_pkg::IRQ_CLEAR_ADDR)) ?
                     pwdata[dcr_pkg::EVT_N-1:0] : 3'h0;

  always_comb begin
    events = 3'h0;
    events[dcr_pkg::EVT_ECC_UNCORR] = ecc_uncorr_valid;
    events[dcr_pkg::EVT_WRLAT] = wrlat_done;
    events[dcr_pkg::EVT_RDLAT] = rdlat_done;
  end

  dcr_event_irq #(
    .N(dcr_pkg::EVT_N)
  ) u_irq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .event_pulse(events),
    .clear(irq_clear),
    .enable(irq_en_q),
    .status(irq_status),
    .irq(irq)
  );

  // ---------------------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------------------

  assign cke_delay = cke_delay_q;
  assign write_latency_base = wrlat_base_q;
  assign read_enable_base = rden_base_q;
  assign termination_alt_enable = term_alt_q;
  assign ctrl_update_min_time = dcr_pkg::UPD_MIN_RST;
  assign ctrl_update_max_time = refresh_interval;
  assign phy_update_type_time = refresh_interval;
  assign phy_update_response_time = refresh_interval;

  // A set disable bit stops the clock for that chip select.
  assign dram_clk_en = ~clk_dis_q;

  // Driving the idle bus avoids floating lines but costs pad power, hence opt-in.
  assign dq_dqs_idle_oe = idle_drive_q && ctrl_idle;

endmodule : dcr_regs

`default_nettype wire

/* verification/dcr_phy_model.sv */
`default_nettype none

module dcr_phy_model (
  // Clock
  input wire logic sys_clk,
  // Command path events and error capture
  output logic wr_cmd_issue, output logic wr_data_issue,
  output logic rd_cmd_issue, output logic rd_data_return,
  output logic ecc_uncorr_valid, output logic [63:0] ecc_uncorr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at start.
  initial begin
    {wr_cmd_issue, wr_data_issue, rd_cmd_issue, rd_data_return, ecc_uncorr_valid} = 5'h00;
    ecc_uncorr_data = 64'h0;
  end
  // Command pulse, then its data pulse gap edges later; gap must be one or more.
  task automatic transfer(input logic rd, input int gap);
    @(posedge sys_clk);
    {rd_cmd_issue, wr_cmd_issue} <= rd ? 2'b10 : 2'b01;
    @(posedge sys_clk);
    {rd_cmd_issue, wr_cmd_issue} <= 2'b00;
    repeat (gap - 1) @(posedge sys_clk);
    {rd_data_return, wr_data_issue} <= rd ? 2'b10 : 2'b01;
    @(posedge sys_clk);
    {rd_data_return, wr_data_issue} <= 2'b00;
  endtask : transfer
  // The data word is only valid with the pulse; afterwards it shows its inverse.
  task automatic ecc_error(input logic [63:0] d);
    @(posedge sys_clk);
    ecc_uncorr_valid <= 1'b1;
    ecc_uncorr_data <= d;
    @(posedge sys_clk);
    ecc_uncorr_valid <= 1'b0;
    ecc_uncorr_data <= ~d;
  endtask : ecc_error
endmodule : dcr_phy_model

`default_nettype wire

/* verification/dcr_regs_bench.sv */
`default_nettype none

module dcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ctrl_idle = 1'b0, pready, pslverr, irq, err, ecc_v, wc, wd, rc, rdr, oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [13:0] refresh_interval = 14'h0C2D;
  logic [63:0] ecc_d;
  logic [3:0] clk_en;
  int mismatches = 0, checked = 0;
  // Ordinary cases: write a word of ones or a pattern, read back what should stick.
  localparam logic [11:0] RA [9] = '{12'h1B0, 12'h1B4, 12'h1D0, 12'h1D4, 12'h1E0,
    12'h1E4, 12'h1F4, 12'h1F0, 12'h1A0};
  localparam logic [31:0] RW [9] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h01208080, 32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [31:0] RE [9] = '{32'h00000007, 32'h0, 32'h000F0101, 32'h0F000004,
    32'h0C2D1F00, 32'h0C2D0C2D, 32'h01208080, 32'h0, 32'h0};

  always #10 sys_clk = ~sys_clk;

  dcr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ecc_uncorr_valid(ecc_v), .ecc_uncorr_data(ecc_d),
    .wr_cmd_issue(wc), .wr_data_issue(wd), .rd_cmd_issue(rc), .rd_data_return(rdr),
    .refresh_interval(refresh_interval), .ctrl_idle(ctrl_idle), .cke_delay(),
    .write_latency_base(), .read_enable_base(), .termination_alt_enable(),
    .ctrl_update_min_time(), .ctrl_update_max_time(), .phy_update_type_time(),
    .phy_update_response_time(), .dram_clk_en(clk_en), .dq_dqs_idle_oe(oe),
    .dll0_enable(), .dll0_phase(), .dll0_precision(), .irq(irq));

  dcr_phy_model u_phy (.sys_clk(sys_clk), .wr_cmd_issue(wc), .wr_data_issue(wd),
    .rd_cmd_issue(rc), .rd_data_return(rdr), .ecc_uncorr_valid(ecc_v), .ecc_uncorr_data(ecc_d));

  // One transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, RA[i], RW[i]);
      apb(1'b0, RA[i], 32'h0);
      chk("row readback", RE[i], rd);
    end
    // A second reset in mid-run must restore the defaults.
    @(posedge sys_clk) nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk) chk("clk_en after reset", 32'hF, {28'h0, clk_en});
    // Clock gating pattern and idle drive only while the controller is idle.
    apb(1'b1, 12'h1D0, 32'h000A0001);
    ctrl_idle <= 1'b1;
    @(negedge sys_clk) chk("oe idle", 32'h1, {31'h0, oe});
    chk("clk_en pattern", 32'h5, {28'h0, clk_en});
    @(posedge sys_clk) ctrl_idle <= 1'b0;
    @(negedge sys_clk) chk("oe busy", 32'h0, {31'h0, oe});
    // Captured error data survives a write attempt; the interrupt stays masked.
    u_phy.ecc_error(64'h0123456789ABCDEF);
    apb(1'b1, 12'h1A4, 32'hFFFFFFFF);
    apb(1'b0, 12'h1A0, 32'h0);
    chk("ecc low", 32'h89ABCDEF, rd);
    apb(1'b0, 12'h1A4, 32'h0);
    chk("ecc high", 32'h01234567, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    // Measured gaps: three for writes, the widest field value for reads.
    u_phy.transfer(1'b0, 3);
    u_phy.transfer(1'b1, 31);
    apb(1'b0, 12'h1D4, 32'h0);
    chk("write gap", 32'h00030004, rd);
    apb(1'b0, 12'h1E0, 32'h0);
    chk("read gap", 32'h0C2D001F, rd);
    // Status, enable and clear.
    apb(1'b0, 12'h300, 32'h0);
    chk("status", 32'h7, rd);
    apb(1'b1, 12'h304, 32'h5);
    @(negedge sys_clk) chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h308, 32'h7);
    apb(1'b0, 12'h300, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Unmapped address is refused.
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    conclude();
  end
endmodule : dcr_regs_bench

`default_nettype wire

/* verification/dcr_regs_checker.sv */
`default_nettype none

module dcr_regs_checker (
  // Clock, reset and bus
  input wire logic sys_clk, input wire logic nrst,
  input wire logic psel, input wire logic penable, input wire logic pwrite,
  input wire logic pready, input wire logic [11:0] paddr, input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Side inputs and configuration outputs
  input wire logic ctrl_idle, input wire logic [13:0] refresh_interval,
  input wire logic [2:0] cke_delay, input wire logic [3:0] write_latency_base,
  input wire logic [4:0] read_enable_base, input wire logic [3:0] ctrl_update_min_time,
  input wire logic [13:0] ctrl_update_max_time, input wire logic [13:0] phy_update_type_time,
  input wire logic [3:0] dram_clk_en, input wire logic dq_dqs_idle_oe,
  input wire logic dll0_enable, input wire logic [7:0] dll0_phase,
  input wire logic [7:0] dll0_precision, input wire logic termination_alt_enable,
  input wire logic [13:0] phy_update_response_time
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------------------
  // Completed transfers
  // ---------------------------------------------------------------------------
  // Completed writes must load their fields; a dram_clk_en change must trace back to a write to 12'h1D0.
  sequence s_wr(logic [11:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence s_rd(logic [11:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  AST_CKE_WR: assert property (s_wr(12'h1B0) |=> cke_delay == $past(pwdata[2:0]))
    else $error("cke delay not taken from write");
  AST_WRBASE_WR: assert property (s_wr(12'h1D4) |=>
    write_latency_base == $past(pwdata[27:24]))
    else $error("write latency base not taken from write");
  AST_MIN_CONST: assert property (ctrl_update_min_time == 4'h4)
    else $error("minimum update time is not four");
  AST_MIN_READ: assert property (s_rd(12'h1D4) |-> prdata[3:0] == 4'h4)
    else $error("minimum update time reads wrong");
  AST_CLK_GATE: assert property (s_wr(12'h1D0) |=> dram_clk_en == ~$past(pwdata[19:16]))
    else $error("clock gate does not follow disable bits");
  AST_CLK_HOLD: assert property ($changed(dram_clk_en) |->
    $past(psel && penable && pwrite && paddr == 12'h1D0))
    else $error("clock gate changed without a write");
  AST_TERM: assert property (s_wr(12'h1D0) |=> termination_alt_enable == $past(pwdata[8]))
    else $error("termination bit wrong");
  AST_IDLE_OE: assert property (!ctrl_idle |-> !dq_dqs_idle_oe)
    else $error("data bus driven while busy");
  AST_MIRROR: assert property (ctrl_update_max_time == refresh_interval &&
    phy_update_type_time == refresh_interval && phy_update_response_time == refresh_interval)
    else $error("update timing does not mirror refresh interval");
  AST_RDBASE_WR: assert property (s_wr(12'h1E0) |=> read_enable_base == $past(pwdata[12:8]))
    else $error("read enable base not taken from write");
  AST_DLL_WR: assert property (s_wr(12'h1F4) |=> dll0_enable != $past(pwdata[24]) &&
    dll0_phase == $past(pwdata[23:16]) && dll0_precision == $past(pwdata[7:0]))
    else $error("lane zero DLL fields wrong");
endmodule : dcr_regs_checker

bind dcr_regs dcr_regs_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .ctrl_idle(ctrl_idle), .refresh_interval(refresh_interval),
  .cke_delay(cke_delay), .write_latency_base(write_latency_base),
  .read_enable_base(read_enable_base), .ctrl_update_min_time(ctrl_update_min_time),
  .ctrl_update_max_time(ctrl_update_max_time), .phy_update_type_time(phy_update_type_time),
  .dram_clk_en(dram_clk_en), .dq_dqs_idle_oe(dq_dqs_idle_oe), .dll0_enable(dll0_enable),
  .dll0_phase(dll0_phase), .dll0_precision(dll0_precision),
  .termination_alt_enable(termination_alt_enable),
  .phy_update_response_time(phy_update_response_time));

`default_nettype wire
